/* hw/mbf_bridge.sv */
`timescale 1ns/10ps
`default_nettype none
module mbf_bridge (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic learn_en,
    input wire logic stp_filter_en,
    input wire logic up_mc_allow,
    input wire logic prov_valid,
    input wire logic [47:0] prov_addr,
    output logic prov_reject,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_dir,
    input wire logic req_host,
    input wire logic [47:0] req_src,
    input wire logic [47:0] req_dst,
    input wire logic req_filter_drop,
    input wire logic req_mc_policy_ok,
    input wire logic req_mc_member_ok,
    output logic dec_valid,
    input wire logic dec_ready,
    output logic dec_fwd,
    output logic [3:0] dec_reason,
    output logic dec_host,
    output logic dec_stale,
    output logic sdt_full
);
    mbf_pkg::mbf_state_e state_r;
    mbf_pkg::mbf_state_e state_nxt;
    logic req_ready_r;
    logic dir_r;
    logic host_r;
    logic [47:0] src_r;
    logic [47:0] dst_r;
    logic filt_r;
    logic pol_r;
    logic mem_r;
    logic dec_valid_r;
    logic dec_fwd_r;
    logic [3:0] dec_reason_r;
    logic dec_host_r;
    logic dec_stale_r;
    logic sdt_full_r;
    logic prov_reject_r;
    logic src_hit;
    logic dst_hit;
    logic loc_hit;
    logic sdt_full_w;
    logic sdt_drop;
    logic stale_w;

    // State decode
    wire in_idle = (state_r == mbf_pkg::ST_IDLE);
    wire in_look = (state_r == mbf_pkg::ST_LOOK);
    wire in_hold = (state_r == mbf_pkg::ST_HOLD);
    wire take = req_valid && req_ready_r;
    wire done = dec_valid_r && dec_ready;

    // Destination classes
    wire is_up = (dir_r == mbf_pkg::DIR_UP);
    wire is_bcast = (dst_r == mbf_pkg::BCAST_ADDR);
    wire is_mcast = dst_r[mbf_pkg::GROUP_BIT] && !is_bcast;
    wire is_stp = stp_filter_en && (dst_r == mbf_pkg::STP_ADDR);
    wire is_ucast = !dst_r[mbf_pkg::GROUP_BIT];

    // Learning: provisioning owns the write port when both want it
    wire learn_ok = in_look && is_up && !src_hit && learn_en && !sdt_full_w && !prov_valid;
    wire src_ok = src_hit || learn_ok;
    wire loc_wr = in_look && is_up && !src_ok;
    wire sdt_wr = prov_valid || learn_ok;
    wire [47:0] sdt_wr_mac = prov_valid ? prov_addr : src_r;
    wire dst_local = loc_hit || dst_hit;

    // Customer to cable decision
    wire [3:0] up_rsn = req_rsn_up(filt_r, is_stp, src_ok, is_bcast, is_mcast, up_mc_allow, dst_local);
    // Cable to customer decision
    wire [3:0] dn_rsn = req_rsn_dn(filt_r, is_stp, is_bcast, src_hit, is_mcast, pol_r && mem_r, dst_hit);
    wire [3:0] rsn_w = is_up ? up_rsn : dn_rsn;

    // Priority order for upstream frames
    function automatic logic [3:0] req_rsn_up(
        input logic filt,
        input logic stp,
        input logic sok,
        input logic bc,
        input logic mc,
        input logic mca,
        input logic loc
    );
        if (filt) begin
            req_rsn_up = mbf_pkg::RSN_FILTER;
        end else if (stp) begin
            req_rsn_up = mbf_pkg::RSN_STP;
        end else if (!sok) begin
            req_rsn_up = mbf_pkg::RSN_SRC_UNSUP;
        end else if (bc) begin
            req_rsn_up = mbf_pkg::RSN_FWD;
        end else if (mc) begin
            req_rsn_up = mca ? mbf_pkg::RSN_FWD : mbf_pkg::RSN_MCAST;
        end else if (loc) begin
            req_rsn_up = mbf_pkg::RSN_LOCAL;
        end else begin
            req_rsn_up = mbf_pkg::RSN_FWD;
        end
    endfunction

    // Priority order for downstream frames
    function automatic logic [3:0] req_rsn_dn(
        input logic filt,
        input logic stp,
        input logic bc,
        input logic shit,
        input logic mc,
        input logic mok,
        input logic dhit
    );
        if (filt) begin
            req_rsn_dn = mbf_pkg::RSN_FILTER;
        end else if (stp) begin
            req_rsn_dn = mbf_pkg::RSN_STP;
        end else if (bc) begin
            req_rsn_dn = shit ? mbf_pkg::RSN_BCAST_SRC : mbf_pkg::RSN_FWD;
        end else if (mc) begin
            req_rsn_dn = mok ? mbf_pkg::RSN_FWD : mbf_pkg::RSN_MCAST;
        end else begin
            req_rsn_dn = dhit ? mbf_pkg::RSN_FWD : mbf_pkg::RSN_UNKNOWN;
        end
    endfunction

    // Supported-device table
    mbf_addr_table #(
        .DEPTH(mbf_pkg::SDT_DEPTH)
    ) u_sdt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(sdt_wr),
        .wr_prov(prov_valid),
        .wr_mac(sdt_wr_mac),
        .wr_drop(sdt_drop),
        .look_a(src_r),
        .hit_a(src_hit),
        .look_b(dst_r),
        .hit_b(dst_hit),
        .full(sdt_full_w)
    );

    // Local non-supported address set
    mbf_addr_table #(
        .DEPTH(mbf_pkg::LOCAL_DEPTH)
    ) u_local (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(loc_wr),
        .wr_prov(1'b0),
        .wr_mac(src_r),
        .wr_drop(),
        .look_a(dst_r),
        .hit_a(loc_hit),
        .look_b(src_r),
        .hit_b(),
        .full()
    );

    // Wait limit on an offered decision
    mbf_age_timer #(
        .LIMIT(mbf_pkg::STALE_CYC)
    ) u_age (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .run(in_hold && !dec_ready),
        .expired(stale_w)
    );

    // Next state: one frame in flight keeps arrival order
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mbf_pkg::ST_IDLE: begin
                if (take) begin
                    state_nxt = mbf_pkg::ST_LOOK;
                end
            end
            mbf_pkg::ST_LOOK: begin
                state_nxt = mbf_pkg::ST_HOLD;
            end
            mbf_pkg::ST_HOLD: begin
                if (done || stale_w) begin
                    state_nxt = mbf_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = mbf_pkg::ST_IDLE;
            end
        endcase
    end

    // Frame capture, host frames share the customer path
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dir_r <= mbf_pkg::DIR_UP;
            host_r <= 1'b0;
            src_r <= mbf_pkg::MAC_RST;
            dst_r <= mbf_pkg::MAC_RST;
            filt_r <= 1'b0;
            pol_r <= 1'b0;
            mem_r <= 1'b0;
        end else if (take) begin
            dir_r <= req_host ? mbf_pkg::DIR_UP : req_dir;
            host_r <= req_host;
            src_r <= req_src;
            dst_r <= req_dst;
            filt_r <= req_filter_drop;
            pol_r <= req_mc_policy_ok;
            mem_r <= req_mc_member_ok;
        end
    end

    // Sequencer and handshake flags
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= mbf_pkg::ST_IDLE;
            req_ready_r <= 1'b0;
            dec_valid_r <= 1'b0;
            dec_stale_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_ready_r <= (state_nxt == mbf_pkg::ST_IDLE);
            dec_valid_r <= (state_nxt == mbf_pkg::ST_HOLD);
            dec_stale_r <= in_hold && !done && stale_w;
        end
    end

    // Decision fields
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dec_fwd_r <= 1'b0;
            dec_reason_r <= mbf_pkg::RSN_FWD;
            dec_host_r <= 1'b0;
        end else if (in_look) begin
            dec_fwd_r <= (rsn_w == mbf_pkg::RSN_FWD);
            dec_reason_r <= rsn_w;
            dec_host_r <= host_r;
        end else if (in_hold && !done && stale_w) begin
            dec_fwd_r <= 1'b0;
            dec_reason_r <= mbf_pkg::RSN_STALE;
        end
    end

    // Status
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sdt_full_r <= 1'b0;
            prov_reject_r <= 1'b0;
        end else begin
            sdt_full_r <= sdt_full_w;
            prov_reject_r <= prov_valid && sdt_drop;
        end
    end

    assign req_ready = req_ready_r;
    assign dec_valid = dec_valid_r;
    assign dec_fwd = dec_fwd_r;
    assign dec_reason = dec_reason_r;
    assign dec_host = dec_host_r;
    assign dec_stale = dec_stale_r;
    assign sdt_full = sdt_full_r;
    assign prov_reject = prov_reject_r;

    // Checks
    chk_learn_hit: assert property (@(posedge sys_clk) disable iff (!nrst)
        learn_ok |=> src_hit)
        else $error("learned source missing from table");

    chk_full_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_look && is_up && !src_hit && sdt_full_w && !filt_r && !is_stp
        |=> dec_valid && dec_reason == mbf_pkg::RSN_SRC_UNSUP)
        else $error("unknown source passed with full table");

    chk_one_decision: assert property (@(posedge sys_clk) disable iff (!nrst)
        dec_valid && dec_ready |=> !dec_valid ##1 !dec_valid)
        else $error("decision offered twice");

    chk_stale_gone: assert property (@(posedge sys_clk) disable iff (!nrst)
        dec_stale |-> !dec_valid && $past(dec_valid) && !dec_fwd)
        else $error("stale pulse without withdrawal");

    chk_in_order: assert property (@(posedge sys_clk) disable iff (!nrst)
        req_valid && req_ready |=> !req_ready [*2])
        else $error("new frame taken while one in flight");

    chk_down_unknown: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_look && !is_up && is_ucast && !dst_hit && !filt_r && !is_stp
        |=> dec_valid && !dec_fwd && dec_reason == mbf_pkg::RSN_UNKNOWN)
        else $error("unknown unicast sent to customer");

    chk_bcast_src: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_look && !is_up && is_bcast && src_hit && !filt_r |=> !dec_fwd)
        else $error("broadcast from supported source sent down");

    chk_mcast_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_look && !is_up && is_mcast && !(pol_r && mem_r) |=> !dec_fwd)
        else $error("multicast passed without both permits");

    chk_local_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_look && is_up && src_ok && is_ucast && loc_hit && !filt_r
        |=> dec_reason == mbf_pkg::RSN_LOCAL)
        else $error("local traffic sent to cable");

    chk_stp_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
        in_look && is_stp |=> !dec_fwd)
        else $error("spanning tree unit forwarded");

    cov_up_fwd: cover property (@(posedge sys_clk) disable iff (!nrst)
        dec_valid && dec_ready && dec_fwd && !$past(dir_r));
    cov_learn_full: cover property (@(posedge sys_clk) disable iff (!nrst)
        learn_ok ##1 sdt_full_w);
    cov_stale: cover property (@(posedge sys_clk) disable iff (!nrst)
        dec_stale);
    cov_prov_evict: cover property (@(posedge sys_clk) disable iff (!nrst)
        prov_valid && sdt_full_w && !sdt_drop);
endmodule
`default_nettype wire

/* hw/mbf_pkg.sv */
package mbf_pkg;
    // Address layout
    localparam int ADDR_W = 48;
    localparam int GROUP_BIT = 40;
    localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;
    localparam logic [47:0] STP_ADDR = 48'h0180_c200_0000;
    localparam logic [47:0] MAC_RST = 48'h0000_0000_0000;

    // Table capacities, build-time choices
    localparam int SDT_DEPTH = 4;
    localparam int LOCAL_DEPTH = 8;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int STALE_US = 100;
    localparam int STALE_CYC = (STALE_US * 1000) / CLK_PERIOD_NS;

    // Direction codes
    localparam logic DIR_UP = 1'b0;
    localparam logic DIR_DOWN = 1'b1;

    // Decision reason codes
    localparam logic [3:0] RSN_FWD = 4'h0;
    localparam logic [3:0] RSN_FILTER = 4'h1;
    localparam logic [3:0] RSN_STP = 4'h2;
    localparam logic [3:0] RSN_UNKNOWN = 4'h3;
    localparam logic [3:0] RSN_BCAST_SRC = 4'h4;
    localparam logic [3:0] RSN_MCAST = 4'h5;
    localparam logic [3:0] RSN_SRC_UNSUP = 4'h6;
    localparam logic [3:0] RSN_LOCAL = 4'h7;
    localparam logic [3:0] RSN_STALE = 4'h8;

    // Request sequencing
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOOK = 3'b010,
        ST_HOLD = 3'b100
    } mbf_state_e;
endpackage

/* hw/mbf_addr_table.sv */
`timescale 1ns/10ps
`default_nettype none
module mbf_addr_table #(
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic wr_prov,
    input wire logic [47:0] wr_mac,
    output logic wr_drop,
    input wire logic [47:0] look_a,
    output logic hit_a,
    input wire logic [47:0] look_b,
    output logic hit_b,
    output logic full
);
    logic [DEPTH-1:0] vld_r;
    logic [DEPTH-1:0] prov_r;
    logic [47:0] mac_r [DEPTH];
    logic [DEPTH-1:0] m_wr;
    logic [DEPTH-1:0] m_a;
    logic [DEPTH-1:0] m_b;

    // Lowest set bit as one-hot
    function automatic logic [DEPTH-1:0] first_one(input logic [DEPTH-1:0] v);
        first_one = v & (~v + {{(DEPTH-1){1'b0}}, 1'b1});
    endfunction

    // Slot choice: existing entry, then free slot, then learned slot for provisioning
    wire [DEPTH-1:0] free_sel = first_one(~vld_r);
    wire [DEPTH-1:0] evict_sel = first_one(vld_r & ~prov_r);
    wire [DEPTH-1:0] tgt = (|m_wr) ? m_wr : ((|free_sel) ? free_sel : (wr_prov ? evict_sel : '0));
    assign wr_drop = wr_en && (tgt == '0);
    assign hit_a = |m_a;
    assign hit_b = |m_b;
    assign full = &vld_r;

    // Entries hold until reset or, for learned entries, eviction by provisioning, no aging
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            assign m_wr[g] = vld_r[g] && (mac_r[g] == wr_mac);
            assign m_a[g] = vld_r[g] && (mac_r[g] == look_a);
            assign m_b[g] = vld_r[g] && (mac_r[g] == look_b);
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    vld_r[g] <= 1'b0;
                    prov_r[g] <= 1'b0;
                    mac_r[g] <= mbf_pkg::MAC_RST;
                end else if (wr_en && tgt[g]) begin
                    vld_r[g] <= 1'b1;
                    prov_r[g] <= (m_wr[g] & prov_r[g]) | wr_prov;
                    mac_r[g] <= wr_mac;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/mbf_age_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module mbf_age_timer #(
    parameter int LIMIT = 1000
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic run,
    output logic expired
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
    logic [CW-1:0] cnt_r;
    logic exp_r;

    // Counts while run is high, saturates at LIMIT - 1
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            if (cnt_r != LAST) begin
                cnt_r <= cnt_r + 1'b1;
            end
            exp_r <= (cnt_r == LAST);
        end
    end
    assign expired = exp_r;
endmodule
`default_nettype wire

/* dv/mbf_frame_sink.sv */
`timescale 1ns/10ps
`default_nettype none
// Far-side consumer of forwarding decisions, prompt or slow
module mbf_frame_sink (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic dec_valid,
    input wire logic dec_fwd,
    input wire logic [3:0] dec_reason,
    input wire logic dec_host,
    input wire logic dec_stale,
    input wire logic [15:0] hold_cyc,
    output logic dec_ready,
    output logic [15:0] n_taken,
    output logic [15:0] n_stale,
    output logic last_fwd,
    output logic [3:0] last_reason,
    output logic last_host
);
    logic [15:0] wait_r;

    initial begin
        dec_ready = 1'b0;
        wait_r = 16'h0000;
        n_taken = 16'h0000;
        n_stale = 16'h0000;
    end

    // Ready is raised off the sampling edge after hold_cyc waiting cycles
    always @(negedge sys_clk) begin
        if (!nrst || !dec_valid) begin
            wait_r <= 16'h0000;
            dec_ready <= 1'b0;
        end else if (wait_r >= hold_cyc) begin
            dec_ready <= 1'b1;
        end else begin
            wait_r <= wait_r + 16'h0001;
        end
    end

    // Record each accepted or withdrawn decision
    always @(posedge sys_clk) begin
        if ((dec_valid && dec_ready) || dec_stale) begin
            last_fwd <= dec_fwd;
            last_reason <= dec_reason;
            last_host <= dec_host;
        end
        if (dec_valid && dec_ready) n_taken <= n_taken + 16'h0001;
        if (dec_stale) n_stale <= n_stale + 16'h0001;
    end
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk, nrst, learn_en, stp_filter_en, up_mc_allow, prov_valid, prov_reject;
    logic req_valid, req_ready, req_dir, req_host, req_filter_drop, req_mc_policy_ok, req_mc_member_ok;
    logic [47:0] prov_addr, req_src, req_dst;
    logic dec_valid, dec_ready, dec_fwd, dec_host, dec_stale, sdt_full, last_fwd, last_host;
    logic [3:0] dec_reason, last_reason;
    logic [15:0] hold_cyc, n_taken, n_stale;
    int err_count, tests_run;
    localparam logic [47:0] UNK = 48'h0200_0000_0b0d;
    localparam logic [47:0] MC = 48'h0100_5e00_0001;

    mbf_bridge DUT (.sys_clk(sys_clk), .nrst(nrst), .learn_en(learn_en), .stp_filter_en(stp_filter_en),
        .up_mc_allow(up_mc_allow), .prov_valid(prov_valid), .prov_addr(prov_addr), .prov_reject(prov_reject),
        .req_valid(req_valid), .req_ready(req_ready), .req_dir(req_dir), .req_host(req_host),
        .req_src(req_src), .req_dst(req_dst), .req_filter_drop(req_filter_drop),
        .req_mc_policy_ok(req_mc_policy_ok), .req_mc_member_ok(req_mc_member_ok), .dec_valid(dec_valid),
        .dec_ready(dec_ready), .dec_fwd(dec_fwd), .dec_reason(dec_reason), .dec_host(dec_host),
        .dec_stale(dec_stale), .sdt_full(sdt_full));

    mbf_frame_sink sink (.sys_clk(sys_clk), .nrst(nrst), .dec_valid(dec_valid), .dec_fwd(dec_fwd),
        .dec_reason(dec_reason), .dec_host(dec_host), .dec_stale(dec_stale), .hold_cyc(hold_cyc),
        .dec_ready(dec_ready), .n_taken(n_taken), .n_stale(n_stale), .last_fwd(last_fwd),
        .last_reason(last_reason), .last_host(last_host));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [47:0] paddr(input int i);
        return 48'h0200_0000_00a0 + 48'(i);
    endfunction

    task automatic fail(input string msg);
        $display("wrong value at %0t ns: %s", $time, msg);
        err_count++;
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (4) @(negedge sys_clk);
        tests_run++;
        if (req_ready !== 1'b0 || sdt_full !== 1'b0) fail("outputs active in reset");
        nrst = 1'b1;
        @(negedge sys_clk);
        tests_run++;
        if (req_ready !== 1'b1 || dec_valid !== 1'b0) fail("ready after reset release");
    endtask

    task automatic provision(input logic [47:0] a, input logic rej);
        @(negedge sys_clk);
        prov_valid = 1'b1;
        prov_addr = a;
        @(negedge sys_clk);
        prov_valid = 1'b0;
        tests_run++;
        if (prov_reject !== rej) fail("provision reject flag");
    endtask

    // One header in, one decision out, judged against the expected outcome
    task automatic frame(input logic dir, input logic host, input logic [47:0] src, input logic [47:0] dst,
                         input logic [2:0] fl, input logic ef, input logic [3:0] er);
        logic [15:0] n0, s0;
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        {req_dir, req_host, req_src, req_dst} = {dir, host, src, dst};
        {req_filter_drop, req_mc_policy_ok, req_mc_member_ok} = fl;
        req_valid = 1'b1;
        n0 = n_taken;
        s0 = n_stale;
        @(posedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        tests_run++;
        if (dec_valid !== 1'b0) fail("decision too early");
        @(negedge sys_clk);
        if (dec_valid !== 1'b1) fail("decision latency");
        k = 0;
        while (n_taken === n0 && n_stale === s0 && k < 3000) begin
            @(negedge sys_clk);
            k++;
        end
        tests_run++;
        if (last_fwd !== ef || last_reason !== er) fail("decision mismatch");
        if (er != 4'h8 && last_host !== host) fail("host echo");
        repeat (2) @(negedge sys_clk);
        tests_run++;
        if ((n_taken + n_stale) !== (n0 + s0 + 16'h0001)) fail("decision count");
    endtask

    task automatic t_prov_full;
        for (int i = 0; i < 4; i++) provision(paddr(i), 1'b0);
        @(negedge sys_clk);
        tests_run++;
        if (sdt_full !== 1'b1) fail("table full status");
        provision(paddr(9), 1'b1);
    endtask

    task automatic t_upstream;
        frame(1'b0, 1'b0, paddr(0), UNK, 3'b000, 1'b1, 4'h0);
        frame(1'b0, 1'b0, paddr(1), mbf_pkg::BCAST_ADDR, 3'b000, 1'b1, 4'h0);
        frame(1'b0, 1'b0, paddr(1), MC, 3'b000, 1'b0, 4'h5);
        up_mc_allow = 1'b1;
        frame(1'b0, 1'b0, paddr(1), MC, 3'b000, 1'b1, 4'h0);
        stp_filter_en = 1'b1;
        frame(1'b0, 1'b0, paddr(2), mbf_pkg::STP_ADDR, 3'b000, 1'b0, 4'h2);
        stp_filter_en = 1'b0;
        frame(1'b0, 1'b0, paddr(2), mbf_pkg::STP_ADDR, 3'b000, 1'b1, 4'h0);
        frame(1'b0, 1'b0, paddr(2), UNK, 3'b100, 1'b0, 4'h1);
        frame(1'b0, 1'b1, paddr(3), UNK, 3'b000, 1'b1, 4'h0);
        frame(1'b0, 1'b1, 48'h0200_0000_0f01, UNK, 3'b000, 1'b0, 4'h6);
    endtask

    task automatic t_downstream;
        frame(1'b1, 1'b0, UNK, paddr(2), 3'b000, 1'b1, 4'h0);
        frame(1'b1, 1'b0, paddr(0), UNK, 3'b000, 1'b0, 4'h3);
        frame(1'b1, 1'b0, paddr(0), mbf_pkg::BCAST_ADDR, 3'b000, 1'b0, 4'h4);
        frame(1'b1, 1'b0, UNK, mbf_pkg::BCAST_ADDR, 3'b000, 1'b1, 4'h0);
        frame(1'b1, 1'b0, UNK, paddr(2), 3'b100, 1'b0, 4'h1);
        for (int m = 0; m < 4; m++) begin
            frame(1'b1, 1'b0, UNK, MC, 3'(m), m == 3, (m == 3) ? 4'h0 : 4'h5);
        end
    endtask

    task automatic t_local;
        learn_en = 1'b1;
        frame(1'b0, 1'b0, 48'h0200_0000_0d01, UNK, 3'b000, 1'b0, 4'h6);
        frame(1'b0, 1'b0, paddr(0), 48'h0200_0000_0d01, 3'b000, 1'b0, 4'h7);
        frame(1'b0, 1'b0, paddr(3), UNK, 3'b000, 1'b1, 4'h0);
        learn_en = 1'b0;
    endtask

    task automatic t_order;
        hold_cyc = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            frame(1'b1, 1'b0, UNK, i[0] ? UNK : paddr(i % 4), 3'b000, !i[0], i[0] ? 4'h3 : 4'h0);
        end
    endtask

    task automatic t_stale;
        hold_cyc = 16'h07d0;
        frame(1'b0, 1'b0, paddr(0), UNK, 3'b000, 1'b0, 4'h8);
        hold_cyc = 16'h0003;
        frame(1'b0, 1'b0, paddr(1), UNK, 3'b000, 1'b1, 4'h0);
    endtask

    task automatic t_reset_clears;
        do_reset();
        frame(1'b0, 1'b0, paddr(0), UNK, 3'b000, 1'b0, 4'h6);
    endtask

    task automatic t_learn;
        learn_en = 1'b1;
        for (int i = 0; i < 4; i++) frame(1'b0, 1'b0, 48'h0200_0000_0e00 + 48'(i), UNK, 3'b000, 1'b1, 4'h0);
        tests_run++;
        if (sdt_full !== 1'b1) fail("full after learning");
        frame(1'b0, 1'b0, 48'h0200_0000_0e04, UNK, 3'b000, 1'b0, 4'h6);
        frame(1'b0, 1'b0, 48'h0200_0000_0e00, UNK, 3'b000, 1'b1, 4'h0);
        provision(paddr(7), 1'b0);
        frame(1'b0, 1'b0, paddr(7), UNK, 3'b000, 1'b1, 4'h0);
    endtask

    initial begin
        {nrst, learn_en, stp_filter_en, up_mc_allow, prov_valid, req_valid} = 6'h00;
        {req_dir, req_host, req_filter_drop, req_mc_policy_ok, req_mc_member_ok} = 5'h00;
        {prov_addr, req_src, req_dst} = {48'h0, 48'h0, 48'h0};
        hold_cyc = 16'h0000;
        err_count = 0;
        tests_run = 0;
        do_reset();
        t_prov_full();
        t_upstream();
        t_downstream();
        t_local();
        t_order();
        t_stale();
        t_reset_clears();
        t_learn();
        tally_and_finish();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(20000 * 100);
        fail("watchdog expired");
        tally_and_finish();
    end
endmodule
`default_nettype wire
